//--- src/ppcfg_pkg.sv
// Package: register map, reset values, pin modes and carrier structs for the port block
package ppcfg_pkg;
   localparam int NPORT = 5;
   localparam logic [7:0] ADDR_DATA [NPORT] = '{8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hFC};
   localparam logic [7:0] ADDR_DIR [NPORT] = '{8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'hFD};
   localparam logic [7:0] ADDR_OPT [NPORT] = '{8'hCC, 8'hCD, 8'hCE, 8'hCF, 8'hFE};
   localparam logic [7:0] REG_RESET = 8'h00;
   // Lines that reach the converter mux (port A high nibble, B, C high nibble, D)
   localparam logic [7:0] ANALOG_CAP [NPORT] = '{8'hF0, 8'hFF, 8'hF0, 8'hFF, 8'h00};
   // Lines with the strong sink driver
   localparam logic [7:0] HISINK_CAP [NPORT] = '{8'h0F, 8'h00, 8'h00, 8'h00, 8'hFF};
   // Shared pin positions
   localparam int POS_OVF = 2;
   localparam int POS_PWM = 3;
   localparam int POS_CAP1 = 4;
   localparam int POS_CAP2 = 5;
   localparam int POS_SOUT = 3;
   localparam int POS_TXD = 5;
   localparam int PORT_A = 0;
   localparam int PORT_D = 3;

   typedef enum logic [2:0] {
      PPCFG_IN_PULL = 3'b000,
      PPCFG_IN_HIZ = 3'b001,
      PPCFG_IN_INT = 3'b010,
      PPCFG_IN_ANA = 3'b011,
      PPCFG_OUT_OD = 3'b100,
      PPCFG_OUT_PP = 3'b101
   } ppcfg_mode_e;

   typedef struct packed {
      logic pwm_pin_enable;
      logic overflow_pin_enable;
      logic reload_select_high;
      logic reload_select_low;
      logic pwm;
      logic timer_overflow_output;
      logic spi_sout;
      logic uart_tx_active;
      logic uart_tx;
   } ppcfg_alt_s;

   typedef struct packed {
      logic we;
      logic re;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ppcfg_bus_s;

   function automatic ppcfg_mode_e ppcfg_decode(input logic dir, input logic opt,
                                                input logic dat);
      if (dir)
         return opt ? PPCFG_OUT_PP : PPCFG_OUT_OD;
      case ({opt, dat})
         2'b00: return PPCFG_IN_PULL;
         2'b01: return PPCFG_IN_HIZ;
         2'b10: return PPCFG_IN_INT;
         default: return PPCFG_IN_ANA;
      endcase
   endfunction
endpackage

//--- src/ppcfg_line.sv
// One line: mode decode to pad controls
module ppcfg_line
   import ppcfg_pkg::*;
#(
   parameter bit ANALOG_OK = 1'b0,
   parameter bit HISINK_OK = 1'b0
) (
   input wire logic i_dir, // Direction bit
   input wire logic i_opt, // Option bit
   input wire logic i_dat, // Value driven when output
   input wire logic i_cfg, // Data latch as input configuration
   input wire logic i_pull_opt, // Pull-up option strap
   output logic o_oe, // Pad drive enable
   output logic o_out, // Pad output level
   output logic o_pull, // Pull-up enable
   output logic o_irq, // Routed to interrupt system
   output logic o_ana, // Connected to converter mux
   output logic o_hisink // Strong sink driver
);
   ppcfg_mode_e mode;
   always_comb begin
      mode = ppcfg_decode(i_dir, i_opt, i_cfg);
      o_oe = 1'b0;
      o_out = 1'b0;
      o_pull = 1'b0;
      o_irq = 1'b0;
      o_ana = 1'b0;
      o_hisink = 1'b0;
      case (mode)
         PPCFG_IN_PULL: o_pull = i_pull_opt;
         PPCFG_IN_HIZ: o_pull = 1'b0;
         PPCFG_IN_INT: begin
            o_pull = 1'b1;
            o_irq = 1'b1;
         end
         PPCFG_IN_ANA: o_ana = ANALOG_OK;
         PPCFG_OUT_OD: begin
            o_oe = ~i_dat;
            o_out = 1'b0;
            o_hisink = HISINK_OK;
         end
         PPCFG_OUT_PP: begin
            o_oe = 1'b1;
            o_out = i_dat;
            o_hisink = HISINK_OK;
         end
         default: o_oe = 1'b0;
      endcase
   end
endmodule // ppcfg_line

//--- src/ppcfg_regs.sv
// Register file for one port: data latch, direction, option
module ppcfg_regs
   import ppcfg_pkg::*;
#(
   parameter logic [7:0] A_DATA = 8'hC0,
   parameter logic [7:0] A_DIR = 8'hC4,
   parameter logic [7:0] A_OPT = 8'hCC
) (
   input wire logic i_clk, // Core clock
   input wire logic i_resetn, // Async reset, low
   input wire ppcfg_pkg::ppcfg_bus_s i_bus, // Register access
   output logic [7:0] o_data, // Data latch
   output logic [7:0] o_dir, // Direction
   output logic [7:0] o_opt, // Option
   output logic o_hit_data, // Address selects data
   output logic o_hit_dir, // Address selects direction
   output logic o_hit_opt // Address selects option
);
   assign o_hit_data = i_bus.addr == A_DATA;
   assign o_hit_dir = i_bus.addr == A_DIR;
   assign o_hit_opt = i_bus.addr == A_OPT;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_data <= REG_RESET;
         o_dir <= REG_RESET;
         o_opt <= REG_RESET;
      end else if (i_bus.we) begin
         if (o_hit_data) o_data <= i_bus.wdata;
         if (o_hit_dir) o_dir <= i_bus.wdata;
         if (o_hit_opt) o_opt <= i_bus.wdata;
      end
   end
endmodule // ppcfg_regs

//--- src/ppcfg_top.sv
// Top: five byte-wide ports with pad control and alternate-function muxing
module ppcfg_top
   import ppcfg_pkg::*;
(
   input wire logic I_REF_CLK, // Core clock, 100 MHz
   input wire logic I_RESETN, // Async reset, low
   input wire logic I_WE, // Data-space write strobe
   input wire logic I_RE, // Data-space read strobe
   input wire logic [7:0] I_ADDR, // Data-space address
   input wire logic [7:0] I_WDATA, // Write data
   input wire logic I_PULL_OPT, // Mask pull-up option
   input wire ppcfg_pkg::ppcfg_alt_s I_ALT, // Peripheral pin functions
   input wire logic [8*NPORT-1:0] I_PIN, // Pad input levels
   output logic [7:0] O_RDATA, // Read data
   output logic O_RVALID, // Read data valid, one cycle
   output logic [8*NPORT-1:0] O_PIN_OUT, // Pad output levels
   output logic [8*NPORT-1:0] O_PIN_OE, // Pad drive enables
   output logic [8*NPORT-1:0] O_PULL, // Pull-up enables
   output logic [8*NPORT-1:0] O_IRQ_EN, // Lines routed to interrupts
   output logic [8*NPORT-1:0] O_ANA_SEL, // Converter mux selects
   output logic [8*NPORT-1:0] O_HISINK, // Strong sink enables
   output logic [8*NPORT-1:0] O_PIN_LEVEL, // Pin levels for peripherals
   output logic O_CAP1_EN, // Capture one pin active
   output logic O_CAP2_EN // Capture two pin active
);
   ppcfg_bus_s bus;
   logic [7:0] dat [NPORT];
   logic [7:0] dir [NPORT];
   logic [7:0] opt [NPORT];
   logic [NPORT-1:0] hit_d, hit_r, hit_o;
   logic [8*NPORT-1:0] drv, cfg, l_oe, l_out, l_pull, l_irq, l_ana, l_hs;
   logic [7:0] next_rdata;

   assign bus = '{we: I_WE, re: I_RE, addr: I_ADDR, wdata: I_WDATA};

   for (genvar p = 0; p < NPORT; p++) begin : g_port
      ppcfg_regs #(
         .A_DATA(ADDR_DATA[p]),
         .A_DIR(ADDR_DIR[p]),
         .A_OPT(ADDR_OPT[p])
      ) u_regs (
         .i_clk(I_REF_CLK),
         .i_resetn(I_RESETN),
         .i_bus(bus),
         .o_data(dat[p]),
         .o_dir(dir[p]),
         .o_opt(opt[p]),
         .o_hit_data(hit_d[p]),
         .o_hit_dir(hit_r[p]),
         .o_hit_opt(hit_o[p])
      );
      for (genvar b = 0; b < 8; b++) begin : g_bit
         ppcfg_line #(
            .ANALOG_OK(ANALOG_CAP[p][b]),
            .HISINK_OK(HISINK_CAP[p][b])
         ) u_line (
            .i_dir(dir[p][b]),
            .i_opt(opt[p][b]),
            .i_dat(drv[8*p+b]),
            .i_cfg(cfg[8*p+b]),
            .i_pull_opt(I_PULL_OPT),
            .o_oe(l_oe[8*p+b]),
            .o_out(l_out[8*p+b]),
            .o_pull(l_pull[8*p+b]),
            .o_irq(l_irq[8*p+b]),
            .o_ana(l_ana[8*p+b]),
            .o_hisink(l_hs[8*p+b])
         );
      end
   end

   // Output source per line; alternate functions override the data latch only
   always_comb begin
      for (int p = 0; p < NPORT; p++) begin
         drv[8*p +: 8] = dat[p];
         cfg[8*p +: 8] = dat[p];
      end
      // Mode is set by the latch; mode decode in output ignores it anyway
      if (I_ALT.pwm_pin_enable && dir[PORT_A][POS_PWM])
         drv[8*PORT_A+POS_PWM] = I_ALT.pwm;
      if (I_ALT.overflow_pin_enable && dir[PORT_A][POS_OVF])
         drv[8*PORT_A+POS_OVF] = I_ALT.timer_overflow_output;
      if (dir[PORT_D][POS_SOUT] && !opt[PORT_D][POS_SOUT])
         drv[8*PORT_D+POS_SOUT] = I_ALT.spi_sout & dat[PORT_D][POS_SOUT];
      if (I_ALT.uart_tx_active)
         drv[8*PORT_D+POS_TXD] = I_ALT.uart_tx;
   end

   // Register read: pin level for input lines, latch for outputs
   always_comb begin
      next_rdata = 8'h00;
      for (int p = 0; p < NPORT; p++) begin
         if (hit_d[p])
            next_rdata = (dir[p] & dat[p]) | (~dir[p] & I_PIN[8*p +: 8]);
         if (hit_r[p])
            next_rdata = dir[p];
         if (hit_o[p])
            next_rdata = opt[p];
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_RDATA <= 8'h00;
         O_RVALID <= 1'b0;
      end else begin
         O_RDATA <= I_RE ? next_rdata : 8'h00;
         O_RVALID <= I_RE;
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_PIN_OUT <= '0;
         O_PIN_OE <= '0;
         O_PULL <= '0;
         O_IRQ_EN <= '0;
         O_ANA_SEL <= '0;
         O_HISINK <= '0;
         O_PIN_LEVEL <= '0;
         O_CAP1_EN <= 1'b0;
         O_CAP2_EN <= 1'b0;
      end else begin
         O_PIN_OUT <= l_out;
         O_PIN_OE <= l_oe;
         O_PULL <= l_pull;
         O_IRQ_EN <= l_irq;
         O_ANA_SEL <= l_ana;
         O_HISINK <= l_hs;
         O_PIN_LEVEL <= I_PIN;
         // Capture only claims the pin while selected and configured as input
         O_CAP1_EN <= I_ALT.reload_select_low & ~dir[PORT_A][POS_CAP1];
         O_CAP2_EN <= I_ALT.reload_select_high & ~dir[PORT_A][POS_CAP2];
      end
   end

   // Pull-up mode with all registers clear after reset
   reset_pull_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (dir[1] == 8'h00 && opt[1] == 8'h00 && dat[1] == 8'h00 && I_PULL_OPT)
      |=> O_PULL[15:8] == 8'hFF)
      else $error("pulled input not enabled");
   hiz_nopull_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (!dir[1][0] && !opt[1][0] && dat[1][0]) |=> !O_PULL[8] && !O_PIN_OE[8])
      else $error("hi-z input pulled or driven");
   int_route_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (!dir[1][0] && opt[1][0] && !dat[1][0]) |=> O_IRQ_EN[8] && O_PULL[8])
      else $error("interrupt input not routed");
   analog_sel_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      O_ANA_SEL[8] |-> $past(!dir[1][0] && opt[1][0] && dat[1][0]))
      else $error("analog select without mode");
   od_drive_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (dir[1][0] && !opt[1][0]) |=> O_PIN_OE[8] == !$past(dat[1][0]) && !O_PIN_OUT[8])
      else $error("open drain drive wrong");
   pp_drive_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (dir[1][0] && opt[1][0]) |=> O_PIN_OE[8] && O_PIN_OUT[8] == $past(dat[1][0]))
      else $error("push-pull drive wrong");
   sequence in_read_s;
      I_RE && I_ADDR == ADDR_DATA[1] && dir[1] == 8'h00;
   endsequence
   pin_read_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      in_read_s |=> O_RVALID && O_RDATA == $past(I_PIN[15:8]))
      else $error("input read not from pin");
   pwm_off_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (!I_ALT.pwm_pin_enable && dir[0][3] && opt[0][3]) |=> O_PIN_OUT[3] == $past(dat[0][3]))
      else $error("pwm pin not ordinary");
   uart_idle_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (!I_ALT.uart_tx_active && dir[3][5] && opt[3][5]) |=> O_PIN_OUT[29] == $past(dat[3][5]))
      else $error("uart idle pin not latch");
   cap_off_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      !I_ALT.reload_select_low |=> !O_CAP1_EN)
      else $error("capture claimed pin");
   cap2_off_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      !I_ALT.reload_select_high |=> !O_CAP2_EN)
      else $error("capture two claimed pin");
   // Serial data only reaches the pad through the open-drain path
   sout_serial_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (dir[3][3] && !opt[3][3])
      |=> O_PIN_OE[27] == !($past(I_ALT.spi_sout) && $past(dat[3][3])))
      else $error("serial out open drain wrong");
   sout_latch_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (dir[3][3] && opt[3][3]) |=> O_PIN_OE[27] && O_PIN_OUT[27] == $past(dat[3][3]))
      else $error("serial out push-pull not latch");
   pwm_on_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (I_ALT.pwm_pin_enable && dir[0][3] && opt[0][3])
      |=> O_PIN_OUT[3] == $past(I_ALT.pwm))
      else $error("pwm pin not driven by timer");
endmodule // ppcfg_top

//--- verif/ppcfg_pads.sv
// Board model: resolves every pad from block drive, board driver and pull-up
module ppcfg_pads (
   input wire logic i_clk, // Toggles the floating level
   input wire logic [39:0] i_out, // Block output levels
   input wire logic [39:0] i_oe, // Block drive enables
   input wire logic [39:0] i_pull, // Pull-up enables
   input wire logic [39:0] i_ext_en, // Board driver enables
   input wire logic [39:0] i_ext_val, // Board driver levels
   output logic [39:0] o_pin // Resolved pad levels
);
   timeunit 1ns;
   timeprecision 1ps;
   logic flt = 1'b0;
   // An undriven pad without pull-up toggles every clock, so a stale level matches it only on every other cycle
   always @(posedge i_clk) flt <= ~flt;
   always_comb begin
      for (int b = 0; b < 40; b++) begin
         if (i_oe[b])
            o_pin[b] = i_out[b];
         else if (i_ext_en[b])
            o_pin[b] = i_ext_val[b];
         else if (i_pull[b])
            o_pin[b] = 1'b1;
         else
            o_pin[b] = flt ^ b[0];
      end
   end
endmodule // ppcfg_pads

//--- verif/ppcfg_top_tb.sv
// Testbench: register accesses, pad modes and shared pin functions
module ppcfg_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ppcfg_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, we = 1'b0, re = 1'b0, pull_opt = 1'b1;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic [39:0] ext_en = '0, ext_val = '0, pin, pout, poe, pull, irq, ana, sink, plev;
   ppcfg_alt_s alt = '0;
   logic rvalid, cap1, cap2;
   int errors = 0, n_checks = 0;
   always #5 clk = ~clk;
   ppcfg_top DUT (.I_REF_CLK(clk), .I_RESETN(rstn), .I_WE(we), .I_RE(re), .I_ADDR(addr),
      .I_WDATA(wdata), .I_PULL_OPT(pull_opt), .I_ALT(alt), .I_PIN(pin), .O_RDATA(rdata),
      .O_RVALID(rvalid), .O_PIN_OUT(pout), .O_PIN_OE(poe), .O_PULL(pull), .O_IRQ_EN(irq),
      .O_ANA_SEL(ana), .O_HISINK(sink), .O_PIN_LEVEL(plev), .O_CAP1_EN(cap1),
      .O_CAP2_EN(cap2));
   ppcfg_pads PADS (.i_clk(clk), .i_out(pout), .i_oe(poe), .i_pull(pull), .i_ext_en(ext_en),
      .i_ext_val(ext_val), .o_pin(pin));
   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic settle();
      repeat (2) @(negedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      we = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk);
      we = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(negedge clk);
      re = 1'b1;
      addr = a;
      @(negedge clk);
      re = 1'b0;
      chk(8'(rvalid), 8'h01, "read valid");
      chk(rdata, exp, what);
   endtask
   task automatic do_reset(input logic po);
      pull_opt = po;
      rstn = 1'b0;
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      settle();
      for (int p = 0; p < NPORT; p++) begin
         chk(pull[8*p+:8], {8{po}}, "reset pull");
         chk(poe[8*p+:8], 8'h00, "reset drive");
         rd(ADDR_DIR[p], REG_RESET, "reset dir");
         rd(ADDR_OPT[p], REG_RESET, "reset opt");
      end
   endtask
   task automatic chk_pads(input int p, input logic [7:0] d, o, v);
      chk(poe[8*p+:8], d & (o | ~v), "oe");
      chk(pout[8*p+:8] & poe[8*p+:8], d & (o | ~v) & v, "out");
      chk(pull[8*p+:8], ~d & ~v, "pull");
      chk(irq[8*p+:8], ~d & o & ~v, "irq");
      chk(ana[8*p+:8], ~d & o & v & ANALOG_CAP[p], "analog");
      chk(sink[8*p+:8], d & HISINK_CAP[p], "sink");
   endtask
   // Last resort against a hang
   initial begin
      #500us;
      errors++;
      report_and_stop();
   end
   initial begin
      int p;
      logic [7:0] d, o, v;
      do_reset(1'b1);
      for (int k = 0; k < 2; k++) begin
         p = k ? 4 : 1;
         for (int m = 0; m < 8; m++) begin
            d = m[2] ? 8'hFF : 8'h00;
            o = m[1] ? 8'hFF : 8'h00;
            v = m[0] ? ((m == 3) ? 8'h01 : 8'hFF) : 8'h00;
            wr(ADDR_DIR[p], d);
            wr(ADDR_OPT[p], o);
            wr(ADDR_DATA[p], v);
            settle();
            chk_pads(p, d, o, v);
         end
      end
      for (p = 0; p < NPORT; p++) begin
         wr(ADDR_DATA[p], 8'h00);
         wr(ADDR_DIR[p], 8'hA0 + 8'(p));
         wr(ADDR_OPT[p], 8'h50 + 8'(p));
      end
      wr(8'hD0, 8'hFF);
      for (p = 0; p < NPORT; p++) begin
         rd(ADDR_DIR[p], 8'hA0 + 8'(p), "dir rw");
         rd(ADDR_OPT[p], 8'h50 + 8'(p), "opt rw");
      end
      rd(8'hD0, 8'h00, "unmapped");
      // Inputs on the high nibble of port B read the board, outputs the latch
      wr(ADDR_DIR[1], 8'h0F);
      wr(ADDR_OPT[1], 8'h0F);
      wr(ADDR_DATA[1], 8'hA5);
      ext_en[15:8] = 8'hF0;
      ext_val[15:8] = 8'h90;
      settle();
      rd(ADDR_DATA[1], 8'h95, "pin read");
      chk(plev[15:8], 8'h95, "pin level");
      // Whole port as plain inputs: every bit of the read comes from the board
      wr(ADDR_OPT[1], 8'h00);
      wr(ADDR_DIR[1], 8'h00);
      ext_en[15:8] = 8'hFF;
      settle();
      rd(ADDR_DATA[1], 8'h90, "all input read");
      wr(ADDR_DIR[PORT_A], 8'h0C);
      wr(ADDR_OPT[PORT_A], 8'h0C);
      wr(ADDR_DATA[PORT_A], 8'h00);
      wr(ADDR_DIR[PORT_D], 8'h28);
      wr(ADDR_OPT[PORT_D], 8'h20);
      wr(ADDR_DATA[PORT_D], 8'h28);
      alt.pwm = 1'b1;
      alt.timer_overflow_output = 1'b1;
      settle();
      chk(8'(pout[POS_OVF+:2]), 8'h00, "timer pins off");
      chk(8'({cap2, cap1}), 8'h00, "capture off");
      chk(8'({poe[8*PORT_D+POS_SOUT], pout[8*PORT_D+POS_SOUT]}), 8'h02, "sout od");
      chk(8'(pout[8*PORT_D+POS_TXD]), 8'h01, "tx idle");
      alt.pwm_pin_enable = 1'b1;
      alt.overflow_pin_enable = 1'b1;
      alt.reload_select_high = 1'b1;
      alt.reload_select_low = 1'b1;
      alt.spi_sout = 1'b1;
      alt.uart_tx_active = 1'b1;
      settle();
      chk(8'(pout[POS_OVF+:2]), 8'h03, "timer pins on");
      chk(8'({cap2, cap1}), 8'h03, "capture on");
      chk(8'(poe[8*PORT_D+POS_SOUT]), 8'h00, "sout release");
      chk(8'(pout[8*PORT_D+POS_TXD]), 8'h00, "tx busy");
      wr(ADDR_OPT[PORT_D], 8'h28);
      wr(ADDR_DATA[PORT_D], 8'h28);
      // Serial level low against a high latch tells the two sources apart
      alt.spi_sout = 1'b0;
      settle();
      chk(8'({poe[8*PORT_D+POS_SOUT], pout[8*PORT_D+POS_SOUT]}), 8'h03, "sout pp");
      do_reset(1'b0);
      report_and_stop();
   end
endmodule // ppcfg_top_tb
